// File: uef_regs.svh
// register offsets, field positions, masks and reset values of the enhanced flow block
`ifndef UEF_REGS_SVH
`define UEF_REGS_SVH
`define UEF_OFF_SPAD  8'h00
`define UEF_OFF_FCTL  8'h04
`define UEF_OFF_EFEA  8'h08
`define UEF_OFF_MCTL  8'h0C
`define UEF_OFF_IEN   8'h10
`define UEF_OFF_FIFO  8'h14
`define UEF_OFF_MSTW  8'h18
`define UEF_OFF_CHAR  8'h1C
`define UEF_OFF_STAT  8'h20
`define UEF_RST_SPAD  8'hFF
`define UEF_RST_ZERO  8'h00
`define UEF_FC_RS485  5
`define UEF_FC_IRINV  4
`define UEF_EF_ACTS   7
`define UEF_EF_ARTS   6
`define UEF_EF_SPEC   5
`define UEF_EF_ENH    4
`define UEF_MC_SEL    2
`define UEF_MC_RTS    1
`define UEF_MC_DTR    0
`define UEF_MSK_IEN   8'hE0
`define UEF_MSK_MCTL  8'hEC
`define UEF_MSK_FIFO  8'h30
`define UEF_MSK_MSTW  8'hFC
`define UEF_TBL_D     2'h3
`define UEF_LVL_MAX   8'h40
`endif

// File: uef_pkg.sv
// types and helper functions of the enhanced flow block
`default_nettype none
package uef_pkg;
	// one-hot states of the half-duplex direction sequencer
	typedef enum logic [2:0] {
		UEF_DIR_IDLE = 3'h1,
		UEF_DIR_SEND = 3'h2,
		UEF_DIR_TURN = 3'h4
	} uef_dir_e;
	// status and strobes from the surrounding uart core
	typedef struct packed {
		logic [6:0] rx_level;   // receive fifo fill
		logic [6:0] rx_trig;    // programmed receive trigger
		logic [6:0] next_hi;    // next trigger step above
		logic [6:0] next_lo;    // next trigger step below
		logic       thr_empty;  // holding register empty
		logic       tsr_empty;  // shift register empty
		logic       tx_load;    // byte loaded for transmit
		logic       bit_tick;   // one pulse per bit time
		logic       rx_valid;   // received character strobe
		logic [7:0] rx_char;    // received character
	} uef_core_in_s;
	// controls back to the uart core
	typedef struct packed {
		logic       tx_irq;     // transmitter interrupt source
		logic       tx_halt;    // stop after current character
		logic       rx_store;   // push last character into fifo
		logic       rx_trig_irq;
		logic       special_irq;
		logic       xoff_irq;
		logic       tx_first;   // send first control pair
		logic       tx_second;  // send second control pair
		logic       irda_rx;    // polarity-corrected ir data
	} uef_core_out_s;
	// enhanced register copies the core acts on
	typedef struct packed {
		logic [7:0] fctl;
		logic [7:0] ien;
		logic [7:0] fifo;
		logic [7:0] mctl;
		logic [7:0] mstw;
	} uef_cfg_s;
	// hysteresis in characters for each code
	function automatic logic [5:0] uef_hyst(input logic [3:0] code);
		case (code)
			4'h0: uef_hyst = 6'h00;
			4'h1: uef_hyst = 6'h04;
			4'h2: uef_hyst = 6'h06;
			4'h3, 4'h4: uef_hyst = 6'h08;
			4'h5: uef_hyst = 6'h10;
			4'h6: uef_hyst = 6'h18;
			4'h7: uef_hyst = 6'h20;
			4'h8: uef_hyst = 6'h28;
			4'h9: uef_hyst = 6'h2C;
			4'hA: uef_hyst = 6'h30;
			4'hB: uef_hyst = 6'h34;
			4'hC: uef_hyst = 6'h0C;
			4'hD: uef_hyst = 6'h14;
			4'hE: uef_hyst = 6'h1C;
			default: uef_hyst = 6'h24;
		endcase
	endfunction : uef_hyst
	// write that keeps masked bits unless unlocked
	function automatic logic [7:0] uef_gate(input logic [7:0] old_v, input logic [7:0] new_v,
		input logic [7:0] mask, input logic en);
		uef_gate = en ? new_v : ((old_v & mask) | (new_v & ~mask));
	endfunction : uef_gate
endpackage : uef_pkg
`default_nettype wire

// File: uef_top.sv
// enhanced feature and flow control registers of one uart channel
//
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "uef_regs.svh"
// Summary of operation
// - scratch byte, no effect, resets to FF
// - two bits pick trigger table A-D
// - tables A-C: flow at next steps
// - rs485 off: interrupt on holding empty
// - rs485: rts high on load, low after
// - rs485: interrupt on shift register empty
// - ir receive polarity select, normal default
// - hysteresis only with table D, reset zero
// - hysteresis code table in characters
// - dual mode: two consecutive control characters
// - transmit bits pick control pair sent
// - receive bits pick pair compared
// - mode 11: either pair or sequence
// - auto cts/dsr halts transmitter while high
// - auto rts/dtr: trigger interrupt, hysteresis drive
// - software output unless hardware flow active
// - special character compare, flag, store
// - second pair with special detect: matched pause not stored
// - enable bit gates writes to the enhanced bits of the legacy registers
// - reset clears enhanced bits and enable
// - select bit: cts/rts or dsr/dtr
// - turnaround delay 0-15 bit times
module uef_top (
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic      [31:0]            hrdata,
	output logic                        hreadyout,
	output logic                        hresp,
	input  wire uef_pkg::uef_core_in_s  core_in,
	output uef_pkg::uef_core_out_s      core_out,
	output uef_pkg::uef_cfg_s           cfg,
	input  wire logic                   cts_n,
	input  wire logic                   dsr_n,
	input  wire logic                   ir_rx_pin,
	output logic                        rts_n,
	output logic                        dtr_n
);
	import uef_pkg::*;

	// one channel per instance, nothing shared between channels
	logic [7:0]  spad_reg;       // scratch byte
	logic [7:0]  fctl_reg;       // feature control
	logic [7:0]  efea_reg;       // enhanced feature
	logic [7:0]  mctl_reg;       // modem control copy
	logic [7:0]  ien_reg;        // interrupt enable copy
	logic [7:0]  fifo_reg;       // fifo control copy
	logic [7:0]  mstw_reg;       // modem status write side
	logic [31:0] chars_reg;      // {pause2, pause1, resume2, resume1}
	logic        wr_pend_reg;    // write data phase pending
	logic [7:0]  wr_addr_reg;    // latched write offset
	logic [31:0] rdata_reg;      // read data for the data phase
	logic [2:0]  sflag_reg;      // {special, pause seen, resume seen}
	logic        flow_off_reg;   // receive side asked to stop
	logic        sw_pause_reg;   // remote sent pause
	logic        pend_on_reg;    // previous char was first resume
	logic        pend_off_reg;   // previous char was first pause
	uef_dir_e    dir_reg;        // direction sequencer
	uef_dir_e    dir_next;
	logic [3:0]  turn_cnt_reg;   // bit times left before turnaround
	logic [2:0]  cts_s_reg;      // {ir, dsr, cts} first stage
	logic [2:0]  pin_s2_reg;     // {ir, dsr, cts} second stage
	uef_core_out_s out_reg;
	logic        rts_n_reg;
	logic        dtr_n_reg;

	// decoded controls
	logic        addr_ok;        // address phase taken
	logic        enh_en;
	logic [1:0]  rx_mode;
	logic [1:0]  tx_mode;
	logic        m_on1, m_on2, m_off1, m_off2;
	logic        is_on, is_off;
	logic        drop_char;
	logic [7:0]  lvl_hi, lvl_lo, sum_hi;
	logic [5:0]  hyst;
	logic        use_hyst;
	logic        flow_in_n;      // selected cts or dsr, active low
	logic        flow_drv_n;     // auto-driven output level
	logic [31:0] rd_mux;

	assign enh_en  = efea_reg[`UEF_EF_ENH];
	assign rx_mode = efea_reg[1:0];
	assign tx_mode = efea_reg[3:2];
	assign addr_ok = hsel & htrans[1] & hready;
	// the slave never stretches a transfer and never errors
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_reg;
	assign core_out  = out_reg;
	assign rts_n     = rts_n_reg;
	assign dtr_n     = dtr_n_reg;
	assign cfg       = '{fctl: fctl_reg, ien: ien_reg, fifo: fifo_reg,
		mctl: mctl_reg, mstw: mstw_reg};

	// bus address phase: latch write target, prepare read data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= `UEF_RST_ZERO;
			rdata_reg   <= 32'h0000_0000;
		end else begin
			wr_pend_reg <= addr_ok & hwrite;
			wr_addr_reg <= haddr[7:0];
			if (addr_ok && !hwrite) begin
				rdata_reg <= rd_mux;
			end
		end
	end

	// read decode, unmapped offsets read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (haddr[7:0])
			`UEF_OFF_SPAD: rd_mux[7:0] = spad_reg;
			`UEF_OFF_FCTL: rd_mux[7:0] = fctl_reg;
			`UEF_OFF_EFEA: rd_mux[7:0] = efea_reg;
			`UEF_OFF_MCTL: rd_mux[7:0] = mctl_reg;
			`UEF_OFF_IEN:  rd_mux[7:0] = ien_reg;
			`UEF_OFF_FIFO: rd_mux[7:0] = fifo_reg;
			`UEF_OFF_MSTW: rd_mux[7:0] = mstw_reg;
			`UEF_OFF_CHAR: rd_mux      = chars_reg;
			`UEF_OFF_STAT: rd_mux[7:0] = {1'b0, dir_reg, sw_pause_reg, sflag_reg};
			default:       rd_mux      = 32'h0000_0000;
		endcase
	end

	// plain registers: scratch, feature control, enhanced feature, characters
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			spad_reg  <= `UEF_RST_SPAD;
			fctl_reg  <= `UEF_RST_ZERO;
			efea_reg  <= `UEF_RST_ZERO;
			chars_reg <= 32'h0000_0000;
		end else if (wr_pend_reg) begin
			case (wr_addr_reg)
				`UEF_OFF_SPAD: spad_reg  <= hwdata[7:0];
				`UEF_OFF_FCTL: fctl_reg  <= hwdata[7:0];
				`UEF_OFF_EFEA: efea_reg  <= hwdata[7:0];
				`UEF_OFF_CHAR: chars_reg <= hwdata;
				default: ;
			endcase
		end
	end

	// enhanced bits of the legacy registers only change while unlocked
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mctl_reg <= `UEF_RST_ZERO;
			ien_reg  <= `UEF_RST_ZERO;
			fifo_reg <= `UEF_RST_ZERO;
			mstw_reg <= `UEF_RST_ZERO;
		end else if (wr_pend_reg) begin
			case (wr_addr_reg)
				`UEF_OFF_MCTL: mctl_reg <= uef_gate(mctl_reg, hwdata[7:0], `UEF_MSK_MCTL, enh_en);
				`UEF_OFF_IEN:  ien_reg  <= uef_gate(ien_reg, hwdata[7:0], `UEF_MSK_IEN, enh_en);
				`UEF_OFF_FIFO: fifo_reg <= uef_gate(fifo_reg, hwdata[7:0], `UEF_MSK_FIFO, enh_en);
				`UEF_OFF_MSTW: mstw_reg <= uef_gate(mstw_reg, hwdata[7:0], `UEF_MSK_MSTW, enh_en);
				default: ;
			endcase
		end
	end

	// pin synchronisers; only the second stage is read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cts_s_reg  <= 3'h3;  // ir idles low, so no false ir data after reset
			pin_s2_reg <= 3'h3;  // flow inputs start deasserted
		end else begin
			cts_s_reg  <= {ir_rx_pin, dsr_n, cts_n};
			pin_s2_reg <= cts_s_reg;
		end
	end

	// control character classification, bit 0 is the first received bit
	assign m_on1  = core_in.rx_char == chars_reg[7:0];
	assign m_on2  = core_in.rx_char == chars_reg[15:8];
	assign m_off1 = core_in.rx_char == chars_reg[23:16];
	assign m_off2 = core_in.rx_char == chars_reg[31:24];

	// receive matching per mode; pairs must arrive back to back in sequence mode
	always_comb begin
		is_on  = 1'b0;
		is_off = 1'b0;
		case (rx_mode)
			2'h2: begin
				is_on  = m_on1;
				is_off = m_off1;
			end
			2'h1: begin
				is_on  = m_on2;
				is_off = m_off2;
			end
			2'h3: begin
				if (tx_mode == 2'h2 || tx_mode == 2'h1) begin
					is_on  = m_on1 | m_on2;
					is_off = m_off1 | m_off2;
				end else begin
					is_on  = pend_on_reg & m_on2;
					is_off = pend_off_reg & m_off2;
				end
			end
			default: ;
		endcase
	end

	// second pause char swallowed when special detect shares it
	assign drop_char = efea_reg[`UEF_EF_SPEC] & m_off2 & (rx_mode == 2'h1);

	// software flow state and sticky receive flags, set beats clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_on_reg  <= 1'b0;
			pend_off_reg <= 1'b0;
			sw_pause_reg <= 1'b0;
			sflag_reg    <= 3'h0;
		end else begin
			if (core_in.rx_valid) begin
				pend_on_reg  <= m_on1;
				pend_off_reg <= m_off1;
			end
			if (rx_mode == 2'h0) begin
				sw_pause_reg <= 1'b0;                        // nothing compared
			end else if (core_in.rx_valid && is_off) begin
				sw_pause_reg <= 1'b1;
			end else if (core_in.rx_valid && is_on) begin
				sw_pause_reg <= 1'b0;
			end
			// write one clears; a same-cycle event keeps its bit
			sflag_reg <= (sflag_reg & ~((wr_pend_reg && wr_addr_reg == `UEF_OFF_STAT)
				? hwdata[2:0] : 3'h0))
				| {core_in.rx_valid & efea_reg[`UEF_EF_SPEC] & m_off2,
				   core_in.rx_valid & is_off, core_in.rx_valid & is_on};
		end
	end

	// receive flow thresholds: next steps or table D hysteresis
	assign hyst     = uef_hyst(fctl_reg[3:0]);
	assign use_hyst = (fctl_reg[7:6] == `UEF_TBL_D) && (hyst != 6'h00);
	assign sum_hi   = {1'b0, core_in.rx_trig} + {2'h0, hyst};
	always_comb begin
		if (use_hyst) begin
			lvl_hi = (sum_hi > `UEF_LVL_MAX) ? `UEF_LVL_MAX : sum_hi;
			lvl_lo = ({1'b0, core_in.rx_trig} > {2'h0, hyst})
				? ({1'b0, core_in.rx_trig} - {2'h0, hyst}) : 8'h00;
		end else begin
			lvl_hi = {1'b0, core_in.next_hi};
			lvl_lo = {1'b0, core_in.next_lo};
		end
	end

	// flow-off latch: on at upper level, off below lower level
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flow_off_reg <= 1'b0;
		end else if (!efea_reg[`UEF_EF_ARTS]) begin
			flow_off_reg <= 1'b0;
		end else if ({1'b0, core_in.rx_level} >= lvl_hi) begin
			flow_off_reg <= 1'b1;
		end else if ({1'b0, core_in.rx_level} < lvl_lo) begin
			flow_off_reg <= 1'b0;
		end
	end

	// direction sequencer for half duplex, counts turnaround in bit times
	always_comb begin
		dir_next = dir_reg;
		case (dir_reg)
			UEF_DIR_IDLE: if (core_in.tx_load) dir_next = UEF_DIR_SEND;
			UEF_DIR_SEND: if (core_in.tsr_empty && core_in.thr_empty && !core_in.tx_load)
				dir_next = (mstw_reg[7:4] == 4'h0) ? UEF_DIR_IDLE : UEF_DIR_TURN;
			UEF_DIR_TURN: begin
				if (core_in.tx_load) dir_next = UEF_DIR_SEND;
				else if (core_in.bit_tick && turn_cnt_reg == 4'h1) dir_next = UEF_DIR_IDLE;
			end
			default: dir_next = UEF_DIR_IDLE;
		endcase
		if (!fctl_reg[`UEF_FC_RS485]) dir_next = UEF_DIR_IDLE;
	end

	// sequencer state and turnaround counter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dir_reg      <= UEF_DIR_IDLE;
			turn_cnt_reg <= 4'h0;
		end else begin
			dir_reg <= dir_next;
			if (dir_reg != UEF_DIR_TURN) begin
				turn_cnt_reg <= mstw_reg[7:4];
			end else if (core_in.bit_tick) begin
				turn_cnt_reg <= turn_cnt_reg - 4'h1;
			end
		end
	end

	// selected flow input and the level an auto-driven output takes
	assign flow_in_n  = mctl_reg[`UEF_MC_SEL] ? pin_s2_reg[1] : pin_s2_reg[0];
	assign flow_drv_n = flow_off_reg;

	// registered outputs to the core and the modem pins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_reg   <= '0;
			rts_n_reg <= 1'b1;
			dtr_n_reg <= 1'b1;
		end else begin
			out_reg.tx_irq      <= fctl_reg[`UEF_FC_RS485] ? core_in.tsr_empty
				: core_in.thr_empty;
			out_reg.tx_halt     <= (efea_reg[`UEF_EF_ACTS] & flow_in_n) | sw_pause_reg;
			out_reg.rx_store    <= core_in.rx_valid & ~drop_char;
			out_reg.rx_trig_irq <= efea_reg[`UEF_EF_ARTS]
				& (core_in.rx_level >= core_in.rx_trig);
			out_reg.special_irq <= sflag_reg[2];
			out_reg.xoff_irq    <= sflag_reg[1];
			out_reg.tx_first    <= tx_mode[1];
			out_reg.tx_second   <= tx_mode[0];
			out_reg.irda_rx     <= pin_s2_reg[2] ^ fctl_reg[`UEF_FC_IRINV];
			// rts: direction control, then auto flow if asserted, else software
			if (fctl_reg[`UEF_FC_RS485]) begin
				rts_n_reg <= (dir_reg != UEF_DIR_IDLE);
			end else if (efea_reg[`UEF_EF_ARTS] && !mctl_reg[`UEF_MC_SEL]
				&& mctl_reg[`UEF_MC_RTS]) begin
				rts_n_reg <= flow_drv_n;
			end else begin
				rts_n_reg <= ~mctl_reg[`UEF_MC_RTS];
			end
			// dtr: auto flow only when selected and asserted by software
			if (efea_reg[`UEF_EF_ARTS] && mctl_reg[`UEF_MC_SEL] && mctl_reg[`UEF_MC_DTR]) begin
				dtr_n_reg <= flow_drv_n;
			end else begin
				dtr_n_reg <= ~mctl_reg[`UEF_MC_DTR];
			end
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_SPAD_WRITE: assert property (wr_pend_reg && wr_addr_reg == `UEF_OFF_SPAD
		|=> spad_reg == $past(hwdata[7:0])) else $error("scratch write lost");
	AST_THR_IRQ: assert property (!fctl_reg[`UEF_FC_RS485]
		|=> out_reg.tx_irq == $past(core_in.thr_empty)) else $error("holding empty irq wrong");
	AST_TSR_IRQ: assert property (fctl_reg[`UEF_FC_RS485] && core_in.tsr_empty
		|=> out_reg.tx_irq) else $error("shift empty irq missing");
	AST_DIR_RAISE: assert property (fctl_reg[`UEF_FC_RS485] && dir_reg == UEF_DIR_IDLE
		&& core_in.tx_load ##1 fctl_reg[`UEF_FC_RS485] |=> rts_n_reg)
		else $error("rts not raised on load");
	AST_IR_POL: assert property (out_reg.irda_rx ==
		($past(pin_s2_reg[2]) ^ $past(fctl_reg[`UEF_FC_IRINV]))) else $error("ir polarity");
	AST_AUTO_CTS: assert property (efea_reg[`UEF_EF_ACTS] && flow_in_n
		|=> out_reg.tx_halt) else $error("transmitter not halted");
	AST_FLOW_HI: assert property ($rose(flow_off_reg)
		|-> $past({1'b0, core_in.rx_level} >= lvl_hi)) else $error("flow off below level");
	AST_SPEC_DROP: assert property (core_in.rx_valid && drop_char
		|=> !out_reg.rx_store && sflag_reg[2] && sflag_reg[1]) else $error("pause2 stored");
	AST_GATE: assert property (wr_pend_reg && wr_addr_reg == `UEF_OFF_MCTL && !enh_en
		|=> (mctl_reg & `UEF_MSK_MCTL) == $past(mctl_reg & `UEF_MSK_MCTL))
		else $error("locked bits changed");
	AST_SEQ_ON: assert property (core_in.rx_valid && rx_mode == 2'h3 && tx_mode == 2'h3
		&& pend_on_reg && m_on2 |=> sflag_reg[0]) else $error("sequence resume missed");
	AST_TURN: assert property (dir_reg == UEF_DIR_TURN |-> turn_cnt_reg != 4'h0)
		else $error("turnaround count empty");

	COV_SPEC: cover property (core_in.rx_valid && drop_char);
	COV_TURN: cover property (dir_reg == UEF_DIR_TURN ##1 dir_reg == UEF_DIR_IDLE);
	COV_FLOW: cover property ($rose(flow_off_reg) && use_hyst);
	COV_PAUSE: cover property ($rose(sw_pause_reg));

endmodule : uef_top
`default_nettype wire

// File: uef_line_model.sv
// far-side modem model driving the flow-control and infrared receive pins
`timescale 1ns/10ps
`default_nettype none
module uef_line_model (
	input  wire logic       hclk,
	input  wire logic [2:0] far_cmd,
	output logic            cts_n,
	output logic            dsr_n,
	output logic            ir_rx_pin
);
	// pins move just after an edge; the block must synchronise them itself
	// one process drives all three pins; levels settle at the first edge
	always @(posedge hclk) begin
		cts_n     <= far_cmd[0];
		dsr_n     <= far_cmd[1];
		ir_rx_pin <= far_cmd[2];
	end
endmodule : uef_line_model
`default_nettype wire

// File: testbench.sv
// self-checking bench of the enhanced flow-control block
`timescale 1ns/10ps
`default_nettype none
`include "uef_regs.svh"
module testbench;
	import uef_pkg::*;
	logic             hclk = 1'b0;    // 40 MHz bus clock
	logic             hresetn = 1'b0; // reset, active low
	logic             hsel = 1'b0;    // slave select
	logic      [31:0] haddr = 32'h0;  // byte address
	logic      [1:0]  htrans = 2'h0;  // transfer type
	logic             hwrite = 1'b0;  // write strobe
	logic      [31:0] hwdata = 32'h0; // write data
	wire logic [31:0] hrdata;         // read data
	wire logic        hreadyout;      // slave ready
	wire logic        hresp;          // response, always okay
	uef_core_in_s     ci = '0;        // uart core status
	uef_core_out_s    co;             // controls to core
	uef_cfg_s         cfg;            // enhanced copies to the core
	logic      [2:0]  far_cmd = 3'h0; // far-side pin levels
	wire logic        cts_n;          // clear-to-send pin
	wire logic        dsr_n;          // data-set-ready pin
	wire logic        ir_rx_pin;      // infrared receive pin
	wire logic        rts_n;          // request-to-send pin
	wire logic        dtr_n;          // terminal-ready pin
	int               fail_count = 0; // mismatches seen
	int               checked = 0;    // comparisons made
	logic      [31:0] rd;             // last read word
	// free-running clock, 25 ns period
	always #12.5 hclk = ~hclk;
	uef_top i_uef_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .core_in(ci), .core_out(co),
		.cfg(cfg), .cts_n(cts_n), .dsr_n(dsr_n), .ir_rx_pin(ir_rx_pin), .rts_n(rts_n),
		.dtr_n(dtr_n));
	uef_line_model i_uef_line_model (.hclk(hclk), .far_cmd(far_cmd), .cts_n(cts_n),
		.dsr_n(dsr_n), .ir_rx_pin(ir_rx_pin));
	// single compare point, counts every comparison
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one word transfer; starts on an edge so inputs only move there
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask : bus
	// sample after registered outputs have settled
	task automatic look(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask : look
	// one received character; the store strobe is judged in its cycle
	task automatic rx(input logic [7:0] c, input logic st);
		@(posedge hclk);
		ci.rx_char <= c;
		ci.rx_valid <= 1'b1;
		@(posedge hclk);
		ci.rx_valid <= 1'b0;
		#1;
		chk(co.rx_store, st);
	endtask : rx
	task automatic t_reset;
		bus(1'b0, `UEF_OFF_SPAD, 32'h0);
		chk(rd, 32'h0000_00FF);
		bus(1'b0, `UEF_OFF_FCTL, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, `UEF_OFF_EFEA, 32'h0);
		chk(rd, 32'h0);
		chk({rts_n, dtr_n}, 2'h3);
		chk({hreadyout, hresp}, 2'h2);
	endtask : t_reset
	// scratch holds a byte; an unmapped word reads zero
	task automatic t_scratch;
		bus(1'b1, `UEF_OFF_SPAD, 32'h0000_005A);
		bus(1'b0, `UEF_OFF_SPAD, 32'h0);
		chk(rd, 32'h0000_005A);
		bus(1'b1, 8'h40, 32'hFFFF_FFFF);
		bus(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
	endtask : t_scratch
	// locked bits keep their last value while the enable bit is clear
	task automatic t_lock;
		bus(1'b1, `UEF_OFF_MCTL, 32'h0000_00FF);
		bus(1'b0, `UEF_OFF_MCTL, 32'h0);
		chk(rd, 32'h0000_0013);
		bus(1'b1, `UEF_OFF_EFEA, 32'h0000_0010);
		bus(1'b1, `UEF_OFF_MCTL, 32'h0000_00FF);
		bus(1'b0, `UEF_OFF_MCTL, 32'h0);
		chk(rd, 32'h0000_00FF);
		look(2);
		chk({rts_n, dtr_n}, 2'h0);
		bus(1'b1, `UEF_OFF_EFEA, 32'h0);
		bus(1'b1, `UEF_OFF_MCTL, 32'h0);
		bus(1'b0, `UEF_OFF_MCTL, 32'h0);
		chk(rd, 32'h0000_00EC);
		chk(cfg.mctl, 32'h0000_00EC);
	endtask : t_lock
	task automatic t_irda;
		bus(1'b1, `UEF_OFF_FCTL, 32'h0);
		far_cmd <= 3'h4;
		look(6);
		chk(co.irda_rx, 1'b1);
		bus(1'b1, `UEF_OFF_FCTL, 32'h0000_0010);
		look(3);
		chk(co.irda_rx, 1'b0);
	endtask : t_irda
	// the select bit must steer the halt to the chosen pin only
	task automatic t_cts;
		bus(1'b1, `UEF_OFF_EFEA, 32'h0000_0090);
		bus(1'b1, `UEF_OFF_MCTL, 32'h0);
		far_cmd <= 3'h1;
		look(5);
		chk(co.tx_halt, 1'b1);
		bus(1'b1, `UEF_OFF_MCTL, 32'h0000_0004);
		look(5);
		chk(co.tx_halt, 1'b0);
		@(posedge hclk);
		far_cmd <= 3'h2;
		look(5);
		chk(co.tx_halt, 1'b1);
		@(posedge hclk);
		far_cmd <= 3'h0;
		look(5);
		chk(co.tx_halt, 1'b0);
	endtask : t_cts
	// fill level walked across trigger, hysteresis and next-step bounds
	task automatic lvl(input logic [6:0] v, input logic exp);
		@(posedge hclk);
		ci.rx_level <= v;
		look(4);
		chk(rts_n, exp);
	endtask : lvl
	task automatic t_hyst;
		bus(1'b1, `UEF_OFF_FCTL, 32'h0000_00C1);
		bus(1'b1, `UEF_OFF_EFEA, 32'h0000_0050);
		bus(1'b1, `UEF_OFF_MCTL, 32'h0000_0002);
		ci.rx_trig <= 7'h14;
		ci.next_hi <= 7'h30;
		ci.next_lo <= 7'h04;
		lvl(7'h17, 1'b0);
		lvl(7'h18, 1'b1);
		chk(co.rx_trig_irq, 1'b1);
		lvl(7'h10, 1'b1);
		lvl(7'h0F, 1'b0);
		bus(1'b1, `UEF_OFF_FCTL, 32'h0000_0041);
		lvl(7'h18, 1'b0);
		lvl(7'h30, 1'b1);
		lvl(7'h05, 1'b1);
		lvl(7'h03, 1'b0);
	endtask : t_hyst
	task automatic t_rs485;
		bus(1'b1, `UEF_OFF_EFEA, 32'h0000_0010);
		ci.thr_empty <= 1'b1;
		bus(1'b1, `UEF_OFF_FCTL, 32'h0);
		look(3);
		chk(co.tx_irq, 1'b1);
		bus(1'b1, `UEF_OFF_FCTL, 32'h0000_0020);
		ci.tx_load <= 1'b1;
		ci.thr_empty <= 1'b0;
		@(posedge hclk);
		ci.tx_load <= 1'b0;
		look(3);
		chk(rts_n, 1'b1);
		@(posedge hclk);
		ci.thr_empty <= 1'b1;
		look(3);
		chk(co.tx_irq, 1'b0);
		chk(rts_n, 1'b1);
		@(posedge hclk);
		ci.tsr_empty <= 1'b1;
		look(4);
		chk(rts_n, 1'b0);
		chk(co.tx_irq, 1'b1);
		// two bit times of turnaround: rts stays high until the second tick
		bus(1'b1, `UEF_OFF_MSTW, 32'h0000_0020);
		@(posedge hclk);
		ci.tx_load <= 1'b1;
		ci.tsr_empty <= 1'b0;
		@(posedge hclk);
		ci.tx_load <= 1'b0;
		ci.tsr_empty <= 1'b1;
		@(posedge hclk);
		ci.bit_tick <= 1'b1;
		@(posedge hclk);
		ci.bit_tick <= 1'b0;
		look(3);
		chk(rts_n, 1'b1);
		@(posedge hclk);
		ci.bit_tick <= 1'b1;
		@(posedge hclk);
		ci.bit_tick <= 1'b0;
		look(3);
		chk(rts_n, 1'b0);
	endtask : t_rs485
	// every transmit pair selection, cleared to zero in between
	task automatic t_swfc;
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, `UEF_OFF_EFEA, 32'h0000_0010);
			bus(1'b1, `UEF_OFF_EFEA, {24'h0, 4'h1, i[1:0], 2'h0});
			look(2);
			chk({co.tx_first, co.tx_second}, i[1:0]);
		end
	endtask : t_swfc
	task automatic t_special;
		bus(1'b1, `UEF_OFF_CHAR, 32'h1311_2221);
		bus(1'b1, `UEF_OFF_EFEA, 32'h0000_0030);
		rx(8'h13, 1'b1);
		look(1);
		chk(co.special_irq, 1'b1);
		bus(1'b1, `UEF_OFF_EFEA, 32'h0000_0010);
		bus(1'b1, `UEF_OFF_EFEA, 32'h0000_0031);
		rx(8'h13, 1'b0);
		look(1);
		chk(co.xoff_irq, 1'b1);
		// first pair only: pause then resume steer the transmitter halt
		bus(1'b1, `UEF_OFF_EFEA, 32'h0000_0010);
		bus(1'b1, `UEF_OFF_EFEA, 32'h0000_0012);
		rx(8'h11, 1'b1);
		look(1);
		chk(co.tx_halt, 1'b1);
		rx(8'h21, 1'b1);
		look(1);
		chk(co.tx_halt, 1'b0);
		// sequence mode: the second resume counts only right after the first
		bus(1'b1, `UEF_OFF_EFEA, 32'h0000_0010);
		bus(1'b1, `UEF_OFF_EFEA, 32'h0000_001F);
		rx(8'h22, 1'b1);
		bus(1'b1, `UEF_OFF_STAT, 32'h0000_0007);
		rx(8'h22, 1'b1);
		bus(1'b0, `UEF_OFF_STAT, 32'h0);
		chk(rd, 32'h0000_0010);
		rx(8'h21, 1'b1);
		rx(8'h22, 1'b1);
		bus(1'b0, `UEF_OFF_STAT, 32'h0);
		chk(rd, 32'h0000_0011);
	endtask : t_special
	// verdict and end of run
	task automatic stop_test;
		if (fail_count == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test
	// main sequence: 12 cycles of reset, then the scenarios
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_scratch;
		t_lock;
		t_irda;
		t_cts;
		t_hyst;
		t_rs485;
		t_swfc;
		t_special;
		stop_test;
	end
	// watchdog well beyond the few hundred cycles the scenarios need
	initial begin
		#200000;
		fail_count++;
		stop_test;
	end
endmodule : testbench
`default_nettype wire
